// File: src/ubr_pkg.sv
// Constants, encodings and types shared by the UART receive block and its baud timer.
// Assumes a single 50 MHz clock and an APB master with 32-bit data.
package ubr_pkg;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] FRAME_OFS = 12'h004;
  localparam logic [11:0] BAUD_OFS = 12'h008;
  localparam logic [11:0] RXDATA_OFS = 12'h00c;
  localparam logic [11:0] STATUS_OFS = 12'h010;
  localparam logic [11:0] MASK_OFS = 12'h014;
  // Control register fields
  localparam int CTRL_UART_BIT = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam int CTRL_DIV8_BIT = 3;
  localparam int CTRL_PINF_BIT = 4;
  localparam int CTRL_PINS_BIT = 5;
  localparam int CTRL_RXEN_BIT = 6;
  // Frame register fields
  localparam int FRAME_FM_LSB = 0;
  localparam int FRAME_NPE_BIT = 2;
  localparam int FRAME_PK_LSB = 3;
  localparam int FRAME_CNT_LSB = 8;
  // Baud register fields
  localparam int BAUD_TCS_LSB = 8;
  // Receive data register fields
  localparam int RX_FULL_BIT = 8;
  localparam int RX_BUSY_BIT = 9;
  // Status and mask bits
  localparam int ST_DONE = 0;
  localparam int ST_PERR = 1;
  localparam int ST_FERR = 2;
  localparam int ST_OVR = 3;
  localparam int ST_BRK = 4;
  localparam int ST_W = 5;
  // Encodings
  localparam logic [1:0] SRC_TIMER = 2'h3;
  localparam logic [1:0] TCS_DIV4 = 2'h1;
  localparam logic [1:0] TCS_DIV16 = 2'h2;
  localparam logic [1:0] PAR_ZERO = 2'h0;
  localparam logic [1:0] PAR_ONE = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [2:0] BITS7_CNT = 3'h6;
  localparam logic [2:0] BITS8_CNT = 3'h7;
  // Eight source ticks per bit; sample in the middle
  localparam logic [2:0] OVS_LAST = 3'h7;
  localparam logic [2:0] OVS_MID = 3'h3;
  localparam logic [7:0] COMPARE_RST = 8'h00;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ubr_rx_state_t;
endpackage : ubr_pkg

// File: src/ubr_baud_if.sv
// Carries baud timer settings to the timer and its tick strobes back to the receiver.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface ubr_baud_if;
  logic [7:0] compare;
  logic [1:0] timerClkSel;
  logic [1:0] clkSrcSel;
  logic divEight;
  logic sampleTick;
  logic bitTick;
  logic timerOut;
  modport gen (input compare, input timerClkSel, input clkSrcSel, input divEight,
               output sampleTick, output bitTick, output timerOut);
  modport core (output compare, output timerClkSel, output clkSrcSel, output divEight,
                input sampleTick, input bitTick, input timerOut);
endinterface : ubr_baud_if

// File: src/ubr_baud_gen.sv
// Baud-rate compare timer, its toggling output and the serial clock divider.
// Assumes settings come from registers on the same clock.
`timescale 1ns/1ns
module ubr_baud_gen (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, active high
  ubr_baud_if.gen bif // Settings in, ticks out
);
  logic [3:0] pre_r, pre_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic tout_r, tout_nxt;
  logic [2:0] div_r, div_nxt;
  logic tclkEn, ovf, srcTick;

  always_comb begin
    pre_nxt = pre_r + 4'h1;
    case (bif.timerClkSel)
      ubr_pkg::TCS_DIV4: tclkEn = (pre_r[1:0] == 2'h3);
      ubr_pkg::TCS_DIV16: tclkEn = (pre_r == 4'hf);
      default: tclkEn = 1'b1;
    endcase
    ovf = tclkEn && (cnt_r == bif.compare);
    cnt_nxt = cnt_r;
    if (ovf) begin
      cnt_nxt = 8'h00;
    end else if (tclkEn) begin
      cnt_nxt = cnt_r + 8'h1;
    end
    // Output toggles per overflow, so one period spans two overflows
    tout_nxt = tout_r ^ ovf;
    srcTick = (bif.clkSrcSel == ubr_pkg::SRC_TIMER) ? (ovf && !tout_r) : 1'b1;
    div_nxt = srcTick ? div_r + 3'h1 : div_r;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_r <= 4'h0;
      cnt_r <= 8'h00;
      tout_r <= 1'b0;
      div_r <= 3'h0;
    end else begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      tout_r <= tout_nxt;
      div_r <= div_nxt;
    end
  end

  assign bif.sampleTick = srcTick;
  assign bif.bitTick = bif.divEight ? (srcTick && div_r == ubr_pkg::OVS_LAST) : srcTick;
  assign bif.timerOut = tout_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_timer_count_wrap: assert property (tclkEn |=>
    cnt_r == (($past(cnt_r) == $past(bif.compare)) ? 8'h00 : $past(cnt_r) + 8'h1))
    else $error("baud timer did not wrap at compare value");
  a_timer_src_rise: assert property ((bif.clkSrcSel == ubr_pkg::SRC_TIMER && srcTick) |=>
    (tout_r && !$past(tout_r)))
    else $error("timer source tick without rising timer output");
  a_div_eight_gap: assert property ((bif.divEight && bif.bitTick) |=> !bif.bitTick [*7])
    else $error("divided bit tick came sooner than eight source ticks");
endmodule : ubr_baud_gen

// File: src/ubr_uart_rx.sv
// UART receive block with baud-rate timer, frame decode, error flags and APB registers.
// Assumes an APB master on clk; the serial input pin is asynchronous to clk.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
// Function
// - UART mode forces bit count from frame mode
// - UART mode forces divide-by-eight of source
// - Divide-by-eight follows prescale bit outside UART mode
// - UART mode ignores clock pin function, style
// - Start edge during completion pulse is missed
// - No-parity receiver takes parity slot as stop
// - Clock source selectable as baud timer output
// - Timer overflows every compare plus one timer clocks
// - Bit rate is overflow rate over sixteen
// - Frame mode selects 7/8 data, 1/2 stops
// - Parity kinds zero, one, odd, even, none
module ubr_uart_rx (
  input wire logic clk, // System clock, 50 MHz
  input wire logic reset, // Async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic rxdPin, // Serial data in
  output logic serialClockPinO, // Serial clock pin level
  output logic serialClockPinOe, // Serial clock pin drive enable
  output logic irq // Level interrupt
);
  ubr_baud_if bif ();

  ubr_baud_gen u_baud (
    .clk(clk),
    .reset(reset),
    .bif(bif)
  );

  function automatic logic parity_bad(input logic [7:0] data, input logic bitVal, input logic [1:0] kind);
    case (kind)
      ubr_pkg::PAR_ZERO: parity_bad = bitVal;
      ubr_pkg::PAR_ONE: parity_bad = !bitVal;
      ubr_pkg::PAR_ODD: parity_bad = !(^{data, bitVal});
      default: parity_bad = ^{data, bitVal};
    endcase
  endfunction : parity_bad

  // Control and configuration registers
  logic uartMode_r, uartMode_nxt;
  logic [1:0] clkSrc_r, clkSrc_nxt;
  logic prescaleDiv8Select_r, prescaleDiv8Select_nxt;
  logic clockPinFunctionSelect_r, clockPinFunctionSelect_nxt;
  logic clockPinStyleSelect_r, clockPinStyleSelect_nxt;
  logic rxEnable_r, rxEnable_nxt;
  logic [1:0] frameModeField_r, frameModeField_nxt;
  logic parityDisableBit_r, parityDisableBit_nxt;
  logic [1:0] parityKindField_r, parityKindField_nxt;
  logic [2:0] xferCountWr_r, xferCountWr_nxt;
  logic [7:0] compare_r, compare_nxt;
  logic [1:0] timerClkSel_r, timerClkSel_nxt;
  logic [ubr_pkg::ST_W-1:0] mask_r, mask_nxt;
  logic [ubr_pkg::ST_W-1:0] status_r, status_nxt;
  logic [7:0] rxData_r, rxData_nxt;
  logic rxFull_r, rxFull_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic bitClk_r, bitClk_nxt;

  // Receiver state
  ubr_pkg::ubr_rx_state_t state_r, state_nxt;
  logic [2:0] phase_r, phase_nxt;
  logic [2:0] bitIdx_r, bitIdx_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic parBit_r, parBit_nxt;
  logic stopIdx_r, stopIdx_nxt;
  logic stopErr_r, stopErr_nxt;
  logic stopHigh_r, stopHigh_nxt;
  logic rxIrqHigh_r, rxIrqHigh_nxt;
  logic rxSync1_r, rxSync2_r, rxSync3_r, rxLvl_r, rxLvl_nxt;

  logic access, wrAcc, rdAcc, mapped, fall, mid, last, complete, rxArmed;
  logic [2:0] transferBitCount;
  logic [ubr_pkg::ST_W-1:0] events;

  assign access = psel && penable;
  assign wrAcc = access && pwrite;
  assign rdAcc = access && !pwrite;
  assign mapped = (paddr == ubr_pkg::CTRL_OFS) || (paddr == ubr_pkg::FRAME_OFS) ||
                  (paddr == ubr_pkg::BAUD_OFS) || (paddr == ubr_pkg::RXDATA_OFS) ||
                  (paddr == ubr_pkg::STATUS_OFS) || (paddr == ubr_pkg::MASK_OFS);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_r;

  // Bit count follows frame mode in UART mode; software value only matters otherwise
  assign transferBitCount = uartMode_r ? (frameModeField_r[1] ? ubr_pkg::BITS8_CNT : ubr_pkg::BITS7_CNT)
                                       : xferCountWr_r;
  assign rxArmed = uartMode_r && rxEnable_r;

  assign bif.compare = compare_r;
  assign bif.timerClkSel = timerClkSel_r;
  assign bif.clkSrcSel = clkSrc_r;
  assign bif.divEight = uartMode_r || prescaleDiv8Select_r;

  // Register writes
  always_comb begin
    uartMode_nxt = uartMode_r;
    clkSrc_nxt = clkSrc_r;
    prescaleDiv8Select_nxt = prescaleDiv8Select_r;
    clockPinFunctionSelect_nxt = clockPinFunctionSelect_r;
    clockPinStyleSelect_nxt = clockPinStyleSelect_r;
    rxEnable_nxt = rxEnable_r;
    frameModeField_nxt = frameModeField_r;
    parityDisableBit_nxt = parityDisableBit_r;
    parityKindField_nxt = parityKindField_r;
    xferCountWr_nxt = xferCountWr_r;
    compare_nxt = compare_r;
    timerClkSel_nxt = timerClkSel_r;
    mask_nxt = mask_r;
    if (wrAcc && paddr == ubr_pkg::CTRL_OFS) begin
      uartMode_nxt = pwdata[ubr_pkg::CTRL_UART_BIT];
      clkSrc_nxt = pwdata[ubr_pkg::CTRL_SRC_LSB +: 2];
      prescaleDiv8Select_nxt = pwdata[ubr_pkg::CTRL_DIV8_BIT];
      clockPinFunctionSelect_nxt = pwdata[ubr_pkg::CTRL_PINF_BIT];
      clockPinStyleSelect_nxt = pwdata[ubr_pkg::CTRL_PINS_BIT];
      rxEnable_nxt = pwdata[ubr_pkg::CTRL_RXEN_BIT];
    end
    if (wrAcc && paddr == ubr_pkg::FRAME_OFS) begin
      frameModeField_nxt = pwdata[ubr_pkg::FRAME_FM_LSB +: 2];
      parityDisableBit_nxt = pwdata[ubr_pkg::FRAME_NPE_BIT];
      parityKindField_nxt = pwdata[ubr_pkg::FRAME_PK_LSB +: 2];
      xferCountWr_nxt = pwdata[ubr_pkg::FRAME_CNT_LSB +: 3];
    end
    if (wrAcc && paddr == ubr_pkg::BAUD_OFS) begin
      compare_nxt = pwdata[7:0];
      timerClkSel_nxt = pwdata[ubr_pkg::BAUD_TCS_LSB +: 2];
    end
    if (wrAcc && paddr == ubr_pkg::MASK_OFS) begin
      mask_nxt = pwdata[ubr_pkg::ST_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      uartMode_r <= 1'b0;
      clkSrc_r <= 2'h0;
      prescaleDiv8Select_r <= 1'b0;
      clockPinFunctionSelect_r <= 1'b0;
      clockPinStyleSelect_r <= 1'b0;
      rxEnable_r <= 1'b0;
      frameModeField_r <= 2'h0;
      parityDisableBit_r <= 1'b0;
      parityKindField_r <= 2'h0;
      xferCountWr_r <= 3'h0;
      compare_r <= ubr_pkg::COMPARE_RST;
      timerClkSel_r <= 2'h0;
      mask_r <= '0;
    end else begin
      uartMode_r <= uartMode_nxt;
      clkSrc_r <= clkSrc_nxt;
      prescaleDiv8Select_r <= prescaleDiv8Select_nxt;
      clockPinFunctionSelect_r <= clockPinFunctionSelect_nxt;
      clockPinStyleSelect_r <= clockPinStyleSelect_nxt;
      rxEnable_r <= rxEnable_nxt;
      frameModeField_r <= frameModeField_nxt;
      parityDisableBit_r <= parityDisableBit_nxt;
      parityKindField_r <= parityKindField_nxt;
      xferCountWr_r <= xferCountWr_nxt;
      compare_r <= compare_nxt;
      timerClkSel_r <= timerClkSel_nxt;
      mask_r <= mask_nxt;
    end
  end

  // Input synchroniser; a level change counts once stages two and three agree
  always_comb begin
    rxLvl_nxt = (rxSync2_r == rxSync3_r) ? rxSync3_r : rxLvl_r;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxSync1_r <= 1'b1;
      rxSync2_r <= 1'b1;
      rxSync3_r <= 1'b1;
      rxLvl_r <= 1'b1;
    end else begin
      rxSync1_r <= rxdPin;
      rxSync2_r <= rxSync1_r;
      rxSync3_r <= rxSync2_r;
      rxLvl_r <= rxLvl_nxt;
    end
  end

  assign fall = (rxSync2_r == rxSync3_r) && !rxSync3_r && rxLvl_r;
  assign mid = bif.sampleTick && (phase_r == ubr_pkg::OVS_MID);
  assign last = bif.sampleTick && (phase_r == ubr_pkg::OVS_LAST);

  // Receive sequencer; eight source ticks per bit give the fixed divide-by-eight
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    bitIdx_nxt = bitIdx_r;
    shift_nxt = shift_r;
    parBit_nxt = parBit_r;
    stopIdx_nxt = stopIdx_r;
    stopErr_nxt = stopErr_r;
    stopHigh_nxt = stopHigh_r;
    complete = 1'b0;
    // Completion pulse stays high until the next source tick
    rxIrqHigh_nxt = bif.sampleTick ? 1'b0 : rxIrqHigh_r;
    if (bif.sampleTick && state_r != ubr_pkg::RX_IDLE) begin
      phase_nxt = phase_r + 3'h1;
    end
    case (state_r)
      ubr_pkg::RX_IDLE: begin
        // A start edge meeting the completion pulse is lost, as the hardware does
        if (rxArmed && fall && !rxIrqHigh_r) begin
          state_nxt = ubr_pkg::RX_START;
          phase_nxt = 3'h0;
          bitIdx_nxt = 3'h0;
          shift_nxt = 8'h00;
          parBit_nxt = 1'b0;
          stopIdx_nxt = 1'b0;
          stopErr_nxt = 1'b0;
          stopHigh_nxt = 1'b0;
        end
      end
      ubr_pkg::RX_START: begin
        if (mid && rxLvl_r) begin
          state_nxt = ubr_pkg::RX_IDLE;
        end else if (last) begin
          state_nxt = ubr_pkg::RX_DATA;
        end
      end
      ubr_pkg::RX_DATA: begin
        if (mid) begin
          shift_nxt[bitIdx_r] = rxLvl_r;
        end
        if (last) begin
          if (bitIdx_r == transferBitCount) begin
            // Without parity the slot after data is read as a stop bit
            state_nxt = parityDisableBit_r ? ubr_pkg::RX_STOP : ubr_pkg::RX_PARITY;
          end else begin
            bitIdx_nxt = bitIdx_r + 3'h1;
          end
        end
      end
      ubr_pkg::RX_PARITY: begin
        if (mid) begin
          parBit_nxt = rxLvl_r;
        end
        if (last) begin
          state_nxt = ubr_pkg::RX_STOP;
        end
      end
      ubr_pkg::RX_STOP: begin
        if (mid) begin
          if (rxLvl_r) begin
            stopHigh_nxt = 1'b1;
          end else begin
            stopErr_nxt = 1'b1;
          end
        end
        if (last) begin
          if (stopIdx_r == frameModeField_r[0]) begin
            complete = 1'b1;
            rxIrqHigh_nxt = 1'b1;
            state_nxt = ubr_pkg::RX_IDLE;
          end else begin
            stopIdx_nxt = 1'b1;
          end
        end
      end
      default: state_nxt = ubr_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ubr_pkg::RX_IDLE;
      phase_r <= 3'h0;
      bitIdx_r <= 3'h0;
      shift_r <= 8'h00;
      parBit_r <= 1'b0;
      stopIdx_r <= 1'b0;
      stopErr_r <= 1'b0;
      stopHigh_r <= 1'b0;
      rxIrqHigh_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      bitIdx_r <= bitIdx_nxt;
      shift_r <= shift_nxt;
      parBit_r <= parBit_nxt;
      stopIdx_r <= stopIdx_nxt;
      stopErr_r <= stopErr_nxt;
      stopHigh_r <= stopHigh_nxt;
      rxIrqHigh_r <= rxIrqHigh_nxt;
    end
  end

  // Event flags, receive buffer and read data; a new event beats a same-cycle clear
  always_comb begin
    events = '0;
    events[ubr_pkg::ST_DONE] = complete;
    events[ubr_pkg::ST_PERR] = complete && !parityDisableBit_r &&
                               parity_bad(shift_r, parBit_r, parityKindField_r);
    events[ubr_pkg::ST_FERR] = complete && stopErr_r;
    events[ubr_pkg::ST_OVR] = complete && rxFull_r;
    events[ubr_pkg::ST_BRK] = complete && (shift_r == 8'h00) && !stopHigh_r &&
                              (parityDisableBit_r || !parBit_r);
    status_nxt = status_r;
    if (wrAcc && paddr == ubr_pkg::STATUS_OFS) begin
      status_nxt = status_r & ~pwdata[ubr_pkg::ST_W-1:0];
    end
    status_nxt = status_nxt | events;
    rxData_nxt = complete ? shift_r : rxData_r;
    rxFull_nxt = complete || (rxFull_r && !(rdAcc && paddr == ubr_pkg::RXDATA_OFS));
    bitClk_nxt = bif.bitTick ? !bitClk_r : bitClk_r;
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        ubr_pkg::CTRL_OFS: begin
          prdata_nxt[ubr_pkg::CTRL_UART_BIT] = uartMode_r;
          prdata_nxt[ubr_pkg::CTRL_SRC_LSB +: 2] = clkSrc_r;
          prdata_nxt[ubr_pkg::CTRL_DIV8_BIT] = prescaleDiv8Select_r;
          prdata_nxt[ubr_pkg::CTRL_PINF_BIT] = clockPinFunctionSelect_r;
          prdata_nxt[ubr_pkg::CTRL_PINS_BIT] = clockPinStyleSelect_r;
          prdata_nxt[ubr_pkg::CTRL_RXEN_BIT] = rxEnable_r;
        end
        ubr_pkg::FRAME_OFS: begin
          prdata_nxt[ubr_pkg::FRAME_FM_LSB +: 2] = frameModeField_r;
          prdata_nxt[ubr_pkg::FRAME_NPE_BIT] = parityDisableBit_r;
          prdata_nxt[ubr_pkg::FRAME_PK_LSB +: 2] = parityKindField_r;
          prdata_nxt[ubr_pkg::FRAME_CNT_LSB +: 3] = transferBitCount;
        end
        ubr_pkg::BAUD_OFS: begin
          prdata_nxt[7:0] = compare_r;
          prdata_nxt[ubr_pkg::BAUD_TCS_LSB +: 2] = timerClkSel_r;
        end
        ubr_pkg::RXDATA_OFS: begin
          prdata_nxt[7:0] = rxData_r;
          prdata_nxt[ubr_pkg::RX_FULL_BIT] = rxFull_r;
          prdata_nxt[ubr_pkg::RX_BUSY_BIT] = (state_r != ubr_pkg::RX_IDLE);
        end
        ubr_pkg::STATUS_OFS: prdata_nxt[ubr_pkg::ST_W-1:0] = status_r;
        ubr_pkg::MASK_OFS: prdata_nxt[ubr_pkg::ST_W-1:0] = mask_r;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_r <= '0;
      rxData_r <= 8'h00;
      rxFull_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      bitClk_r <= 1'b1;
    end else begin
      status_r <= status_nxt;
      rxData_r <= rxData_nxt;
      rxFull_r <= rxFull_nxt;
      prdata_r <= prdata_nxt;
      bitClk_r <= bitClk_nxt;
    end
  end

  assign irq = |(status_r & mask_r);
  // Clock pin is left undriven in UART mode whatever its selections say
  assign serialClockPinO = clockPinStyleSelect_r ? 1'b0 : bitClk_r;
  assign serialClockPinOe = !uartMode_r && clockPinFunctionSelect_r &&
                            (!clockPinStyleSelect_r || !bitClk_r);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_hazard_edge;
    state_r == ubr_pkg::RX_IDLE && rxArmed && fall && rxIrqHigh_r;
  endsequence
  sequence s_done_seven;
    complete && uartMode_r && !frameModeField_r[1];
  endsequence

  a_auto_bit_count: assert property (uartMode_r |->
    transferBitCount == (frameModeField_r[1] ? ubr_pkg::BITS8_CNT : ubr_pkg::BITS7_CNT))
    else $error("bit count not forced from frame mode");
  a_div8_forced: assert property (uartMode_r |-> bif.divEight)
    else $error("divide-by-eight not forced in UART mode");
  a_pin_ignored: assert property (uartMode_r |-> !serialClockPinOe)
    else $error("clock pin driven in UART mode");
  a_start_missed: assert property (s_hazard_edge |=> state_r == ubr_pkg::RX_IDLE)
    else $error("start edge during completion pulse was taken");
  a_noparity_stop: assert property ((state_r == ubr_pkg::RX_DATA && last &&
    bitIdx_r == transferBitCount && parityDisableBit_r) |=> state_r == ubr_pkg::RX_STOP)
    else $error("no-parity frame did not go straight to stop");
  a_seven_bit_data: assert property (s_done_seven |=> !rxData_r[7] && rxFull_r)
    else $error("seven-bit frame stored an eighth bit");
  a_parity_forced: assert property ((complete && !parityDisableBit_r &&
    parityKindField_r == ubr_pkg::PAR_ZERO && parBit_r) |=> status_r[ubr_pkg::ST_PERR])
    else $error("forced-zero parity violation not flagged");
  a_set_beats_clear: assert property ((complete && wrAcc && paddr == ubr_pkg::STATUS_OFS &&
    pwdata[ubr_pkg::ST_DONE]) |=> status_r[ubr_pkg::ST_DONE] && (irq || !mask_r[ubr_pkg::ST_DONE]))
    else $error("completion lost to same-cycle clear");
endmodule : ubr_uart_rx

// File: bench/ubr_remote_tx.sv
// Remote sender on the serial line: start, data LSB first, optional parity, stops.
// Assumes the bench calls send and gives the bit time in clk cycles.
`timescale 1ns/1ns
module ubr_remote_tx (
  input wire logic clk, // System clock
  output logic txd // Serial line, idle high
);
  initial txd = 1'b1;
  task automatic put_bit(input logic b, input int bitClks);
    @(posedge clk);
    txd <= b;
    repeat (bitClks - 1) @(posedge clk);
  endtask : put_bit
  // Parity kind 0 zero, 1 one, 2 odd, 3 even, 4 none
  task automatic send(input logic [7:0] d, input int nBits, input int par, input int stops, input int bitClks);
    logic [7:0] m;
    m = (nBits == 7) ? (d & 8'h7f) : d;
    put_bit(1'b0, bitClks);
    for (int j = 0; j < nBits; j++) begin
      put_bit(m[j], bitClks);
    end
    if (par < 4) begin
      put_bit(par == 1 ? 1'b1 : par == 2 ? ~^m : par == 3 ? ^m : 1'b0, bitClks);
    end
    repeat (stops) put_bit(1'b1, bitClks);
  endtask : send
endmodule : ubr_remote_tx

// File: bench/uart_baud_and_sequential_rx_tb_top.sv
// Self-checking bench: APB master, remote sender, random frames through the receiver.
// Assumes a zero-wait APB slave and the baud timer as serial clock source.
`timescale 1ns/1ns
module uart_baud_and_sequential_rx_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, q;
  logic pready, pslverr, rxd, sckO, sckOe, irq, e;
  logic [7:0] d;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int bitClks, fm, nb, stops, c, t;
  int txT[8] = '{0, 1, 2, 3, 4, 3, 1, 3};
  int rxT[8] = '{0, 1, 2, 3, 4, 2, 4, 3};
  ubr_uart_rx ubr_uart_rx_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxdPin(rxd),
    .serialClockPinO(sckO), .serialClockPinOe(sckOe), .irq(irq));
  ubr_remote_tx ubr_remote_tx_i (.clk(clk), .txd(rxd));
  initial begin
    forever #10 clk = ~clk;
  end
  task end_sim;
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Bound well above the longest frame sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'he17b5444));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, ubr_pkg::STATUS_OFS, 32'h0);
    chk("status reset", 32'h0, q);
    chk("irq reset", 32'h0, irq);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped err", 32'h1, e);
    chk("unmapped data", 32'h0, q);
    c = $urandom_range(2, 0);
    t = $urandom_range(3, 0);
    // Slowest timer clock only with the smallest compare, to keep the run short
    if (t == 2) c = 0;
    bitClks = (c + 1) * 2 * 8 * (t == 1 ? 4 : t == 2 ? 16 : 1);
    apb(1'b1, ubr_pkg::BAUD_OFS, c | (t << ubr_pkg::BAUD_TCS_LSB));
    apb(1'b0, ubr_pkg::BAUD_OFS, 32'h0);
    chk("baud", c | (t << ubr_pkg::BAUD_TCS_LSB), q[9:0]);
    // Pin function on, prescale and pin style random: none may have an effect in UART mode
    apb(1'b1, ubr_pkg::CTRL_OFS, 32'h57 | ($urandom_range(7, 0) << 3));
    @(posedge clk);
    chk("pin oe", 32'h0, sckOe);
    for (int i = 0; i < 8; i++) begin
      fm = (i == 7) ? ($urandom_range(1, 0) * 2) : $urandom_range(3, 0);
      nb = fm[1] ? 8 : 7;
      stops = (i == 7) ? 2 : fm % 2 + 1;
      apb(1'b1, ubr_pkg::FRAME_OFS, fm | ((rxT[i] == 4) << 2) | ((rxT[i] % 4) << 3));
      apb(1'b0, ubr_pkg::FRAME_OFS, 32'h0);
      chk("bit count", nb - 1, q[10:8]);
      apb(1'b1, ubr_pkg::MASK_OFS, i % 2);
      repeat (i >= 6 ? 2 : 1) begin
        d = $urandom;
        ubr_remote_tx_i.send(d, nb, txT[i], stops, bitClks);
      end
      // No workaround: the all-ones frame right behind is lost, data and flags stay from the first
      if (i == 4) ubr_remote_tx_i.send(8'hff, nb, txT[i], stops, bitClks);
      repeat (bitClks) @(posedge clk);
      chk("irq", i % 2, irq);
      apb(1'b0, ubr_pkg::STATUS_OFS, 32'h0);
      chk("status", 1 | ((i == 5) << 1) | ((i >= 6) << 3), q);
      apb(1'b0, ubr_pkg::RXDATA_OFS, 32'h0);
      chk("rxdata", {1'b1, d & (nb == 8 ? 8'hff : 8'h7f)}, q[8:0]);
      apb(1'b1, ubr_pkg::STATUS_OFS, 32'h1f);
      apb(1'b0, ubr_pkg::STATUS_OFS, 32'h0);
      chk("status clear", 32'h0, q);
      chk("irq clear", 32'h0, irq);
    end
    end_sim();
  end
endmodule : uart_baud_and_sequential_rx_tb_top
